/* File: hw/framer_pkg.sv */
// Purpose: shared constants and carriers for the vicinity-tag request/response framer
// Assumes: flag bits numbered 1..8 sit at byte bits 0..7
// Notes:   error classes are a plain encoding, not a state machine
package framer_pkg;

  // host-side command codes and the tag inventory command code
  localparam logic [7:0] CMD_PROTOCOL   = 8'h02;
  localparam logic [7:0] CMD_EXCHANGE   = 8'h04;
  localparam logic [7:0] TAG_INVENTORY  = 8'h01;
  // result codes returned toward the host
  localparam logic [7:0] RESULT_OK      = 8'h80;
  localparam logic [7:0] RESULT_NO_TAG  = 8'h87;
  localparam logic [7:0] RESULT_NONE    = 8'h00;

  // request flag byte positions (numbered bit n at byte bit n-1)
  localparam int FLG_SUBCARRIER = 0;
  localparam int FLG_RATE       = 1;
  localparam int FLG_INVENTORY  = 2;
  localparam int FLG_EXTENDED   = 3;
  localparam int FLG_BIT5       = 4;
  localparam int FLG_BIT6       = 5;
  localparam int FLG_OPTION     = 6;
  localparam int FLG_RESERVED   = 7;
  // response flag byte positions
  localparam int RSP_ERROR      = 0;
  localparam int RSP_EXTENDED   = 3;
  localparam logic [7:0] RSP_RESERVED_MASK = 8'hF6;

  // identifier layout
  localparam logic [7:0] UID_PREFIX   = 8'hE0;
  localparam int         UID_BYTES    = 8;
  localparam logic [7:0] MASK_MAX_BITS = 8'h40;

  // frame check sequence, reflected form
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  // tag error codes
  localparam logic [7:0] ERR_CMD_UNSUPPORTED  = 8'h01;
  localparam logic [7:0] ERR_CMD_UNRECOGNISED = 8'h02;
  localparam logic [7:0] ERR_OPTION           = 8'h03;
  localparam logic [7:0] ERR_UNKNOWN          = 8'h0F;
  localparam logic [7:0] ERR_BLOCK_FIRST      = 8'h10;
  localparam logic [7:0] ERR_BLOCK_LAST       = 8'h14;
  localparam logic [7:0] ERR_CUSTOM_FIRST     = 8'hA0;
  localparam logic [7:0] ERR_CUSTOM_LAST      = 8'hDF;

  // default frame wait, in clock cycles
  localparam int WAIT_CYCLES_DEFAULT = 65536;

  typedef enum logic [3:0] {
    EC_NONE          = 4'h0,
    EC_CMD_UNSUP     = 4'h1,
    EC_CMD_BAD       = 4'h2,
    EC_OPTION        = 4'h3,
    EC_UNKNOWN       = 4'h4,
    EC_BLOCK_MISSING = 4'h5,
    EC_BLOCK_LOCKED  = 4'h6,
    EC_BLOCK_FROZEN  = 4'h7,
    EC_BLOCK_PROG    = 4'h8,
    EC_BLOCK_LOCKFL  = 4'h9,
    EC_CUSTOM        = 4'hA,
    EC_OTHER         = 4'hB
  } error_class_e;

  typedef struct packed {
    logic two_subcarriers;
    logic high_rate;
    logic inventory;
    logic extended;
    logic select_only;
    logic addressed;
    logic afi_present;
    logic slot_count_select;
    logic option;
    logic reserved_set;
  } req_flags_s;

  typedef struct packed {
    logic [7:0]  prefix;
    logic [7:0]  maker;
    logic [47:0] serial;
  } uid_s;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } tx_word_s;

endpackage

/* File: hw/iso15693_request_response_framer.sv */
// Purpose: frames host tag requests toward the RF side and parses tag responses
// Assumes: host and RF byte streams are synchronous to clk
// Notes:   one request in flight; a new one waits until the answer or the timeout
`timescale 1ns/1ps
`default_nettype none

// request byte buffer between host parser and RF transmitter
module fifo_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  // storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module iso15693_request_response_framer
  import framer_pkg::*;
#(
  parameter int WAIT_CYCLES = WAIT_CYCLES_DEFAULT,
  parameter int FIFO_DEPTH  = 32
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         crc_append,
  input  wire logic         host_valid,
  output logic              host_ready,
  input  wire logic [7:0]   host_data,
  output logic              host_refused,
  output logic              protocol_selected,
  output var  req_flags_s   req_flags,
  output logic [7:0]        req_command,
  output logic [7:0]        mask_length,
  output logic              req_format_error,
  output logic              rf_tx_sof,
  output logic              rf_tx_valid,
  input  wire logic         rf_tx_ready,
  output logic [7:0]        rf_tx_data,
  output logic              rf_tx_eof,
  input  wire logic         rf_rx_valid,
  input  wire logic [7:0]   rf_rx_data,
  input  wire logic         rf_rx_last,
  output logic              resp_done,
  output logic              resp_error,
  output logic              resp_extended,
  output logic              resp_reserved_set,
  output logic [7:0]        error_code,
  output error_class_e      error_class,
  output logic [7:0]        storage_format_byte,
  output var  uid_s         tag_uid,
  output logic              uid_prefix_ok,
  output logic [7:0]        result_code
);
  localparam int WW = $clog2(WAIT_CYCLES + 1);
  // a zero wait would time out before any answer could start
  if (WAIT_CYCLES < 1) begin : g_bad_wait
    $error("wait count must be positive");
  end

  typedef enum logic [2:0] {
    H_CMD  = 3'b001,
    H_LEN  = 3'b010,
    H_BODY = 3'b100
  } host_state_e;

  typedef enum logic [6:0] {
    T_IDLE = 7'b0000001,
    T_SOF  = 7'b0000010,
    T_DATA = 7'b0000100,
    T_CRCL = 7'b0001000,
    T_CRCH = 7'b0010000,
    T_EOF  = 7'b0100000,
    T_WAIT = 7'b1000000
  } tx_state_e;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  host_state_e hstate;
  tx_state_e   tstate;
  logic [7:0]  remaining;
  logic        in_exchange;
  logic [7:0]  body_idx;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  tx_word_s    fifo_out;
  logic [15:0] crc;
  logic [WW-1:0] wait_count;
  logic [3:0]  rx_idx;
  logic        rx_err_frame;
  logic        tx_load;

  // host byte decode
  wire host_take   = host_valid && host_ready;
  wire body_byte   = (hstate == H_BODY) && host_take;
  wire last_body   = remaining == 8'h01;
  wire push_fifo   = body_byte && in_exchange;
  wire mask_at_idx = body_idx == (req_flags.afi_present ? 8'h03 : 8'h02);
  assign host_ready = (hstate == H_BODY) ? (fifo_in_ready || !in_exchange) : 1'b1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hstate            <= H_CMD;
      remaining         <= 8'h00;
      in_exchange       <= 1'b0;
      body_idx          <= 8'h00;
      host_refused      <= 1'b0;
      protocol_selected <= 1'b0;
    end else begin
      host_refused <= 1'b0;
      unique case (hstate)
        H_CMD: if (host_take) begin
          in_exchange <= host_data == CMD_EXCHANGE && protocol_selected;
          host_refused <= host_data == CMD_EXCHANGE && !protocol_selected;
          if (host_data == CMD_PROTOCOL) protocol_selected <= 1'b1;
          hstate <= H_LEN;
        end
        H_LEN: if (host_take) begin
          remaining <= host_data;
          body_idx  <= 8'h00;
          hstate    <= (host_data == 8'h00) ? H_CMD : H_BODY;
        end
        H_BODY: if (host_take) begin
          remaining <= remaining - 8'h01;
          body_idx  <= body_idx + 8'h01;
          if (last_body) hstate <= H_CMD;
        end
      endcase
    end
  end

  // request field capture; flag bits from byte bits 0..7, bits 5 and 6 decoded by the inventory bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_flags        <= '0;
      req_command      <= 8'h00;
      mask_length      <= 8'h00;
      req_format_error <= 1'b0;
    end else if (push_fifo) begin
      if (body_idx == 8'h00) begin
        req_flags.two_subcarriers   <= host_data[FLG_SUBCARRIER];
        req_flags.high_rate         <= host_data[FLG_RATE];
        req_flags.inventory         <= host_data[FLG_INVENTORY];
        req_flags.extended          <= host_data[FLG_EXTENDED];
        req_flags.select_only       <= !host_data[FLG_INVENTORY] && host_data[FLG_BIT5];
        req_flags.addressed         <= !host_data[FLG_INVENTORY] && host_data[FLG_BIT6];
        req_flags.afi_present       <= host_data[FLG_INVENTORY] && host_data[FLG_BIT5];
        req_flags.slot_count_select <= host_data[FLG_INVENTORY] && host_data[FLG_BIT6];
        req_flags.option            <= host_data[FLG_OPTION];
        req_flags.reserved_set      <= host_data[FLG_RESERVED];
        req_format_error            <= host_data[FLG_RESERVED];
        mask_length                 <= 8'h00;
      end else if (body_idx == 8'h01) begin
        req_command <= host_data;
      end else if (req_flags.inventory && req_command == TAG_INVENTORY && mask_at_idx) begin
        mask_length <= host_data;
        if (host_data > MASK_MAX_BITS) req_format_error <= 1'b1;
      end
    end
  end

  // delimiters are not host bytes; only request bytes are queued
  fifo_buffer #(.WIDTH($bits(tx_word_s)), .DEPTH(FIFO_DEPTH)) req_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push_fifo),
    .in_ready  (fifo_in_ready),
    .in_data   ({last_body, host_data}),
    .out_valid (fifo_out_valid),
    .out_ready (tx_load && tstate == T_DATA),
    .out_data  (fifo_out)
  );

  // transmit output register frees when empty or taken
  assign tx_load = !rf_tx_valid || rf_tx_ready;
  wire wait_done = wait_count == WW'(1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tstate      <= T_IDLE;
      rf_tx_valid <= 1'b0;
      rf_tx_data  <= 8'h00;
      rf_tx_sof   <= 1'b0;
      rf_tx_eof   <= 1'b0;
      crc         <= CRC_INIT;
      wait_count  <= '0;
    end else begin
      rf_tx_sof <= 1'b0;
      rf_tx_eof <= 1'b0;
      if (rf_tx_ready) rf_tx_valid <= 1'b0;
      unique case (tstate)
        T_IDLE: if (fifo_out_valid) tstate <= T_SOF;
        T_SOF: begin
          rf_tx_sof <= 1'b1;
          crc       <= CRC_INIT;
          tstate    <= T_DATA;
        end
        T_DATA: if (tx_load && fifo_out_valid) begin
          rf_tx_valid <= 1'b1;
          rf_tx_data  <= fifo_out.data;
          crc         <= crc_step(crc, fifo_out.data);
          if (fifo_out.last) tstate <= crc_append ? T_CRCL : T_EOF;
        end
        T_CRCL: if (tx_load) begin
          rf_tx_valid <= 1'b1;
          rf_tx_data  <= ~crc[7:0];
          tstate      <= T_CRCH;
        end
        T_CRCH: if (tx_load) begin
          rf_tx_valid <= 1'b1;
          rf_tx_data  <= ~crc[15:8];
          tstate      <= T_EOF;
        end
        T_EOF: if (tx_load) begin
          rf_tx_eof  <= 1'b1;
          wait_count <= WW'(WAIT_CYCLES);
          tstate     <= T_WAIT;
        end
        T_WAIT: begin
          wait_count <= wait_count - WW'(1);
          if (rf_rx_valid && rf_rx_last) tstate <= T_IDLE;
          else if (wait_done && rx_idx == 4'h0) tstate <= T_IDLE;
        end
      endcase
    end
  end

  // error code classes, general then memory block in ascending order
  wire in_block  = error_code >= ERR_BLOCK_FIRST && error_code <= ERR_BLOCK_LAST;
  wire in_custom = error_code >= ERR_CUSTOM_FIRST && error_code <= ERR_CUSTOM_LAST;
  wire [3:0] block_class = 4'(EC_BLOCK_MISSING) + 4'(error_code - ERR_BLOCK_FIRST);
  assign error_class = !resp_error                        ? EC_NONE :
                       error_code == ERR_CMD_UNSUPPORTED  ? EC_CMD_UNSUP :
                       error_code == ERR_CMD_UNRECOGNISED ? EC_CMD_BAD :
                       error_code == ERR_OPTION           ? EC_OPTION :
                       error_code == ERR_UNKNOWN          ? EC_UNKNOWN :
                       in_block                           ? error_class_e'(block_class) :
                       in_custom                          ? EC_CUSTOM : EC_OTHER;
  assign uid_prefix_ok = tag_uid.prefix == UID_PREFIX;

  // response parse; identifier arrives least significant byte first
  wire rx_take = rf_rx_valid && tstate == T_WAIT;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_idx              <= 4'h0;
      rx_err_frame        <= 1'b0;
      resp_done           <= 1'b0;
      resp_error          <= 1'b0;
      resp_extended       <= 1'b0;
      resp_reserved_set   <= 1'b0;
      error_code          <= 8'h00;
      storage_format_byte <= 8'h00;
      tag_uid             <= '0;
      result_code         <= RESULT_NONE;
    end else begin
      resp_done <= 1'b0;
      if (tstate == T_WAIT && wait_done && rx_idx == 4'h0 && !rx_take) begin
        result_code <= RESULT_NO_TAG;
        resp_done   <= 1'b1;
      end
      if (rx_take) begin
        if (rx_idx != 4'hF) rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0) begin
          resp_error        <= rf_rx_data[RSP_ERROR];
          rx_err_frame      <= rf_rx_data[RSP_ERROR];
          resp_extended     <= rf_rx_data[RSP_EXTENDED];
          resp_reserved_set <= |(rf_rx_data & RSP_RESERVED_MASK);
          error_code        <= 8'h00;
        end else if (rx_idx == 4'h1 && rx_err_frame) begin
          error_code <= rf_rx_data;
        end else if (rx_idx == 4'h1) begin
          storage_format_byte <= rf_rx_data;
        end else if (!rx_err_frame && rx_idx <= 4'(UID_BYTES + 1)) begin
          tag_uid <= {rf_rx_data, tag_uid[63:8]};
        end
        if (rf_rx_last) begin
          rx_idx      <= 4'h0;
          result_code <= RESULT_OK;
          resp_done   <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: testbench/tag_model.sv */
// Purpose: RF tag stand-in that takes request frames and answers them
// Assumes: framer changes its transmit signals just after rising clk
// Notes:   idle rx data shows the inverse of the last byte, not a held value
`timescale 1ns/1ps
`default_nettype none
module tag_model
  import framer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       rf_tx_sof,
  input  wire logic       rf_tx_valid,
  output logic            rf_tx_ready,
  input  wire logic [7:0] rf_tx_data,
  input  wire logic       rf_tx_eof,
  output logic            rf_rx_valid,
  output logic [7:0]      rf_rx_data,
  output logic            rf_rx_last,
  input  wire logic [7:0] rsp_flags,
  input  wire logic [7:0] err_code,
  input  wire logic       silent,
  input  wire logic       stall
);
  localparam logic [63:0] UID = 64'hE03C0123456789AB; // maker and serial arbitrary
  logic [7:0] got [64];
  int         n_got;
  logic       tick;
  // capture frame bytes; ready only every other cycle, a slow reader
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      n_got <= 0;
      tick <= 1'b0;
      rf_tx_ready <= 1'b0;
    end else begin
      tick <= ~tick;
      rf_tx_ready <= ~stall & tick;
      if (rf_tx_sof)
        n_got <= 0;
      else if (rf_tx_valid && rf_tx_ready) begin
        got[n_got] <= rf_tx_data;
        n_got <= n_got + 1;
      end
    end
  end
  // answer each frame end unless told to stay quiet
  initial begin
    logic [7:0] rsp [10];
    int         len;
    rf_rx_valid = 1'b0;
    rf_rx_data  = 8'h00;
    rf_rx_last  = 1'b0;
    forever begin
      @(negedge clk);
      if (rf_tx_eof && !silent) begin
        rsp[0] = rsp_flags;
        rsp[1] = rsp_flags[RSP_ERROR] ? err_code : 8'h5A;
        for (int i = 0; i < 8; i++)
          rsp[i+2] = UID[8*i +: 8];
        len = rsp_flags[RSP_ERROR] ? 2 : 10;
        repeat (3) @(posedge clk);
        for (int i = 0; i < len; i++) begin
          rf_rx_valid <= 1'b1;
          rf_rx_data  <= rsp[i];
          rf_rx_last  <= (i == len - 1);
          @(posedge clk);
        end
        rf_rx_valid <= 1'b0;
        rf_rx_last  <= 1'b0;
        rf_rx_data  <= ~rsp[len-1];
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/framer_asserts.sv */
// Purpose: property checks on the framer top ports
// Assumes: tag answers start a few cycles after frame end
// Notes:   timeout bound allows a little slack around the count
`timescale 1ns/1ps
`default_nettype none
module framer_asserts
  import framer_pkg::*;
#(
  parameter int WAIT_CYCLES = 50
) (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         host_refused,
  input wire logic         protocol_selected,
  input wire logic         rf_tx_sof,
  input wire logic         rf_tx_valid,
  input wire logic         rf_tx_ready,
  input wire logic [7:0]   rf_tx_data,
  input wire logic         rf_tx_eof,
  input wire logic         rf_rx_valid,
  input wire logic         rf_rx_last,
  input wire logic         resp_done,
  input wire logic         resp_error,
  input wire logic [7:0]   error_code,
  input wire error_class_e error_class,
  input wire logic [7:0]   mask_length,
  input wire logic         req_format_error,
  input wire uid_s         tag_uid,
  input wire logic         uid_prefix_ok,
  input wire logic [7:0]   result_code
);
  logic armed;
  int   wait_cnt;
  // wait window after frame end; count restarts on any tag byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed    <= 1'b0;
      wait_cnt <= 0;
    end else begin
      armed    <= rf_tx_eof | (armed & ~resp_done);
      wait_cnt <= (armed & ~rf_rx_valid & ~rf_tx_eof) ? wait_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_sof_then_data: assert property (rf_tx_sof |=> !rf_tx_sof && rf_tx_valid)
    else $error("frame start not followed by first byte");
  a_tx_held: assert property (rf_tx_valid && !rf_tx_ready |=> rf_tx_valid && $stable(rf_tx_data))
    else $error("transmit byte dropped before taken");
  a_done_on_last: assert property (armed && rf_rx_valid && rf_rx_last |=> resp_done && result_code == RESULT_OK)
    else $error("response end not reported");
  a_no_tag_code: assert property (armed && wait_cnt == WAIT_CYCLES - 3 |-> ##[1:6] (resp_done && result_code == RESULT_NO_TAG))
    else $error("silent tag not timed out");
  a_refuse_unsel: assert property (host_refused |-> !protocol_selected)
    else $error("refusal after protocol select");
  a_select_sticky: assert property ($rose(protocol_selected) |=> protocol_selected[*8])
    else $error("protocol select lost");
  a_uid_prefix: assert property (uid_prefix_ok == (tag_uid.prefix == UID_PREFIX))
    else $error("identifier prefix flag wrong");
  a_block_class: assert property (resp_error && error_code inside {[ERR_BLOCK_FIRST:ERR_BLOCK_LAST]} |-> error_class == error_class_e'(4'(error_code[3:0] + 4'h5)))
    else $error("block error class wrong");
  a_unknown_class: assert property (resp_error && error_code == ERR_UNKNOWN |-> error_class == EC_UNKNOWN)
    else $error("unknown error class wrong");
  a_mask_limit: assert property ($changed(mask_length) && mask_length > MASK_MAX_BITS |-> ##[0:1] req_format_error)
    else $error("oversized mask not flagged");
  c_frame: cover property (rf_tx_sof ##[1:40] rf_tx_eof);
  c_timeout: cover property (resp_done && result_code == RESULT_NO_TAG);
  c_refused: cover property (host_refused);
endmodule
bind iso15693_request_response_framer framer_asserts #(.WAIT_CYCLES(WAIT_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: host-side byte frames through the framer against a tag model
// Assumes: short frame wait so timeouts stay cheap
// Notes:   fixed waits only where the frame may legally be withheld
`timescale 1ns/1ps
`default_nettype none
module testbench
  import framer_pkg::*;
;
  localparam int W = 50;
  logic clk = 1'b0, reset_n = 1'b0, crc_append = 1'b0, host_valid = 1'b0;
  logic [7:0] host_data = 8'h00, rsp_flags = 8'h00, err_code = 8'h00;
  logic silent = 1'b0, stall = 1'b0;
  logic host_ready, host_refused, protocol_selected, req_format_error, rf_tx_sof;
  logic rf_tx_valid, rf_tx_ready, rf_tx_eof, rf_rx_valid, rf_rx_last, resp_done;
  logic resp_error, resp_extended, resp_reserved_set, uid_prefix_ok;
  logic [7:0] req_command, mask_length, rf_tx_data, rf_rx_data, error_code;
  logic [7:0] storage_format_byte, result_code;
  req_flags_s req_flags;
  error_class_e error_class;
  uid_s tag_uid;
  int errors = 0, n_tests = 0, cycles = 0, n_refused = 0, n_full = 0, n_done = 0;
  iso15693_request_response_framer #(.WAIT_CYCLES(W), .FIFO_DEPTH(32)) dut (.*);
  tag_model tag (.*);
  always #12.5 clk = ~clk;
  task automatic close_out();
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // event counts and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (host_refused) n_refused <= n_refused + 1;
    if (host_valid && !host_ready) n_full <= n_full + 1;
    if (resp_done) n_done <= n_done + 1;
    if (cycles == 8000) begin
      errors++;
      close_out();
    end
  end
  // bytes back to back; each held until the framer takes it
  task automatic frame(input logic [7:0] b [$]);
    logic ok;
    host_valid = 1'b1;
    foreach (b[i]) begin
      host_data = b[i];
      do begin
        ok = host_ready;
        @(posedge clk);
        @(negedge clk);
      end while (!ok);
    end
    host_valid = 1'b0;
  endtask
  task automatic wait_done(input int lim);
    int k;
    k = n_done;
    repeat (lim) begin
      @(negedge clk);
      if (n_done != k) break;
    end
    chk(n_done != k, 1);
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  initial begin
    logic [7:0] codes [9] = '{8'h01, 8'h02, 8'h03, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
    error_class_e cls [9] = '{EC_CMD_UNSUP, EC_CMD_BAD, EC_OPTION, EC_UNKNOWN,
      EC_BLOCK_MISSING, EC_BLOCK_LOCKED, EC_BLOCK_FROZEN, EC_BLOCK_PROG, EC_BLOCK_LOCKFL};
    logic [7:0] req [$];
    logic [15:0] c;
    req_flags_s f;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    // exchange before protocol select is eaten and flagged
    frame('{8'h04, 8'h03, 8'h26, 8'h01, 8'h00});
    repeat (4) @(negedge clk);
    chk(n_refused, 1);
    chk(tag.n_got, 0);
    frame('{8'h02, 8'h02, 8'h01, 8'h00});
    @(negedge clk);
    chk(protocol_selected, 1);
    // plain inventory, tag reports extended and a reserved bit
    rsp_flags = 8'h48;
    frame('{8'h04, 8'h03, 8'h26, 8'h01, 8'h00});
    wait_done(60);
    f = req_flags;
    chk({f.two_subcarriers, f.high_rate, f.inventory, f.extended, f.afi_present,
         f.slot_count_select, f.option, f.reserved_set}, 8'h64);
    chk({req_command, mask_length}, 16'h0100);
    chk({tag.n_got, tag.got[0], tag.got[1], tag.got[2]}, {32'd3, 24'h260100});
    chk({result_code, storage_format_byte}, 16'h805A);
    chk({resp_error, resp_extended, resp_reserved_set, uid_prefix_ok}, 4'h7);
    chk(tag_uid, tag.UID);
    // every general and memory block error code, with checksum appended by the framer
    crc_append = 1'b1;
    req = '{8'h3B, 8'h20, 8'h00};
    c = crc16(req);
    rsp_flags = 8'h09;
    foreach (codes[i]) begin
      err_code = codes[i];
      frame('{8'h04, 8'h03, 8'h3B, 8'h20, 8'h00});
      wait_done(80);
      chk(error_class, cls[i]);
      chk({resp_error, resp_extended, error_code}, {2'b11, codes[i]});
    end
    f = req_flags;
    chk({f.two_subcarriers, f.high_rate, f.inventory, f.extended, f.select_only,
         f.addressed, f.option, f.reserved_set}, 8'hDC);
    chk({tag.n_got, tag.got[3], tag.got[4]}, {32'd5, c[7:0], c[15:8]});
    // quiet tag runs into the frame wait
    silent = 1'b1;
    frame('{8'h04, 8'h03, 8'h26, 8'h01, 8'h00});
    wait_done(W + 40);
    chk(result_code, RESULT_NO_TAG);
    // reserved flag bit and oversized mask; frame may be withheld
    frame('{8'h04, 8'h03, 8'hA6, 8'h01, 8'h00});
    repeat (2) @(negedge clk);
    chk(req_format_error, 1);
    repeat (W + 30) @(negedge clk);
    frame('{8'h04, 8'h03, 8'h26, 8'h01, 8'h41});
    repeat (2) @(negedge clk);
    chk({mask_length, req_format_error}, {8'h41, 1'b1});
    repeat (W + 30) @(negedge clk);
    // fill the buffer past full while the tag stalls, then drain
    req = '{8'h04, 8'h28};
    for (int i = 0; i < 40; i++)
      req.push_back(8'(i));
    stall = 1'b1;
    fork
      frame(req);
      begin
        repeat (60) @(negedge clk);
        stall = 1'b0;
      end
    join
    wait_done(W + 120);
    chk(n_full > 0, 1);
    chk(tag.n_got, 42);
    close_out();
  end
endmodule
`default_nettype wire
